/* File: pmpd_pkg.sv */
// Shared constants and types for the PLL mode and power-down controller
package pmpd_pkg;

    // Register byte offsets on the register bus
    localparam logic [7:0] OFFS_CPU_CONTROL_STATUS = 8'h00;
    localparam logic [7:0] OFFS_CLOCK_STATUS = 8'h04;

    // Sleep field position inside the control word
    localparam int SLEEP_LSB = 10;
    localparam int SLEEP_W = 6;
    localparam int SLEEP_STRB_LANE = 1;
    localparam logic [5:0] SLEEP_RESET = 6'h00;

    // Sleep field encodings
    localparam logic [5:0] SLEEP_NONE = 6'h00;
    localparam logic [5:0] SLEEP_HALT_ENABLED = 6'h09;
    localparam logic [5:0] SLEEP_HALT_ANY = 6'h11;
    localparam logic [5:0] SLEEP_PLL_OUT_STOP = 6'h1a;
    localparam logic [5:0] SLEEP_PLL_IN_STOP = 6'h1c;

    // Multiply-select strap encodings
    localparam logic [1:0] MULT_BYPASS = 2'h0;
    localparam logic [1:0] MULT_X6 = 2'h1;
    localparam logic [1:0] MULT_X12 = 2'h2;
    localparam logic [1:0] MULT_RESERVED = 2'h3;

    // Timing: typical lock, margin, worst case, then cycles at the clock rate
    localparam int CLK_MHZ = 40;
    localparam int LOCK_TYP_NS = 75000;
    localparam int LOCK_MARGIN_PCT = 150;
    localparam int LOCK_WORST_NS = LOCK_TYP_NS * (100 + LOCK_MARGIN_PCT) / 100;
    localparam int LOCK_WORST_CYCLES = (LOCK_WORST_NS * CLK_MHZ + 999) / 1000;
    localparam int HALT_DELAY_CYCLES = 8;
    localparam int STRAP_SETTLE_CYCLES = 2;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Controller states
    typedef enum logic [2:0] {ST_STRAP, ST_LOCK, ST_RUN, ST_HALT_PEND, ST_HALT, ST_STOP_PEND, ST_STOP, ST_FAULT}
        pmpd_state_t;

    // Status word contents, low bits of the status register
    typedef struct packed {
        logic strapBad;
        logic clockStopped;
        logic coreHalted;
        logic locked;
        logic [1:0] multSelect;
    } pmpd_status_t;

endpackage

/* File: pmpd_clock_ctrl.sv */
// PLL mode selection, lock wait and power-down clock gating with an AXI4-Lite register port
`timescale 1ns/1ps
module pmpd_clock_ctrl
    import pmpd_pkg::*;
#(
    parameter int LOCK_CYCLES = LOCK_WORST_CYCLES,
    parameter int ADDR_W = 8
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic multSelectHi,
    input wire logic multSelectLo,
    input wire logic irqPending,
    input wire logic irqEnabled,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic cpuClockEn,
    output logic intrClockEn,
    output logic xferClockEn,
    output logic pllOutRun,
    output logic pllInRun,
    output logic periphClockDiv4,
    output logic periphClockDiv6,
    output logic resumeIsr,
    output logic resumeDirect
);

    localparam int LOCK_W = $clog2(LOCK_CYCLES + 1);
    // Refuse a lock count the counter cannot serve; the shared counter must also reach the strap settle count
    if (LOCK_CYCLES < STRAP_SETTLE_CYCLES || ADDR_W < 8)
    begin : gen_bad_param
        $error("pmpd_clock_ctrl: LOCK_CYCLES must cover the strap settle count and ADDR_W be at least 8");
    end

    logic [1:0] strapMeta; // First synchroniser stage, read only by strapSync
    logic [1:0] strapSync; // Synchronised straps
    logic [1:0] multSelect; // Strap value caught after reset release
    pmpd_state_t state;
    pmpd_state_t next_state;
    logic [LOCK_W-1:0] waitCnt; // Lock wait and strap settle counter
    logic [3:0] haltCnt; // Delay from field write to halt or stop
    logic [5:0] sleepField; // Power-down field of the control word
    logic [5:0] pendCode; // Mode code being entered
    logic div4Cnt;
    logic [1:0] div6Cnt;
    // Write channel holding registers
    logic awHeld;
    logic wHeld;
    logic [ADDR_W-1:0] awAddrHeld;
    logic [31:0] wDataHeld;
    logic [3:0] wStrbHeld;
    // Bus decode
    wire awTake = s_axi_awvalid & s_axi_awready;
    wire wTake = s_axi_wvalid & s_axi_wready;
    wire arTake = s_axi_arvalid & s_axi_arready;
    wire doWrite = awHeld & wHeld & ~s_axi_bvalid;
    wire wrCtlHit = awAddrHeld == ADDR_W'(OFFS_CPU_CONTROL_STATUS);
    wire wrStaHit = awAddrHeld == ADDR_W'(OFFS_CLOCK_STATUS);
    wire sleepWrite = doWrite & wrCtlHit & wStrbHeld[SLEEP_STRB_LANE];
    wire [5:0] sleepWdata = wDataHeld[SLEEP_LSB +: SLEEP_W];
    wire rdCtlHit = s_axi_araddr == ADDR_W'(OFFS_CPU_CONTROL_STATUS);
    wire rdStaHit = s_axi_araddr == ADDR_W'(OFFS_CLOCK_STATUS);
    // Mode decode of a written field value
    wire isHaltCode = (sleepWdata == SLEEP_HALT_ENABLED) | (sleepWdata == SLEEP_HALT_ANY);
    wire isStopCode = (sleepWdata == SLEEP_PLL_OUT_STOP) | (sleepWdata == SLEEP_PLL_IN_STOP);
    wire wakeEnabled = irqPending & irqEnabled;
    wire wakeAny = irqPending;
    wire wakeNow = (pendCode == SLEEP_HALT_ANY) ? wakeAny : wakeEnabled;
    // Status and read data
    pmpd_status_t statusWord;
    assign statusWord.strapBad = state == ST_FAULT;
    assign statusWord.clockStopped = state == ST_STOP;
    assign statusWord.coreHalted = state == ST_HALT;
    assign statusWord.locked = (state != ST_STRAP) & (state != ST_LOCK) & (state != ST_FAULT);
    assign statusWord.multSelect = multSelect;
    wire [31:0] ctlReadWord = {16'h0000, sleepField, 10'h000};
    wire [31:0] staReadWord = {26'h0000000, statusWord};
    wire [31:0] readWord = rdCtlHit ? ctlReadWord : (rdStaHit ? staReadWord : 32'h00000000);
    wire [1:0] readResp = (rdCtlHit | rdStaHit) ? RESP_OKAY : RESP_SLVERR;
    wire [1:0] writeResp = (wrCtlHit | wrStaHit) ? RESP_OKAY : RESP_SLVERR;
    // Reference-derived clocks run once locked and until a stop mode lands
    wire refRun = (next_state == ST_RUN) | (next_state == ST_HALT_PEND) | (next_state == ST_HALT)
        | (next_state == ST_STOP_PEND);
    // Straps cross from pins through two flops; pull-downs make an open pin read low
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            strapMeta <= 2'h0;
            strapSync <= 2'h0;
        end
        else
        begin
            strapMeta <= {multSelectHi, multSelectLo};
            strapSync <= strapMeta;
        end
    end
    // Sequencer next state; only reset leaves the stop and fault states
    always_comb
    begin
        next_state = state;
        case (state)
            ST_STRAP:
            begin
                if (waitCnt == LOCK_W'(STRAP_SETTLE_CYCLES))
                begin
                    if (strapSync == MULT_BYPASS)
                        next_state = ST_RUN;
                    else if (strapSync == MULT_RESERVED)
                        next_state = ST_FAULT;
                    else
                        next_state = ST_LOCK;
                end
            end
            ST_LOCK:
                if (waitCnt == LOCK_W'(LOCK_CYCLES))
                    next_state = ST_RUN;
            ST_RUN:
            begin
                if (sleepWrite & isHaltCode)
                    next_state = ST_HALT_PEND;
                else if (sleepWrite & isStopCode)
                    next_state = ST_STOP_PEND;
            end
            ST_HALT_PEND:
                if (haltCnt == 4'(HALT_DELAY_CYCLES))
                    next_state = ST_HALT;
            ST_HALT:
                if (wakeNow)
                    next_state = ST_RUN;
            ST_STOP_PEND:
                if (haltCnt == 4'(HALT_DELAY_CYCLES))
                    next_state = ST_STOP;
            ST_STOP:
                next_state = ST_STOP;
            default:
                next_state = state;
        endcase
    end
    // Sequencer registers, counters and the sleep field
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state <= ST_STRAP;
            waitCnt <= '0;
            haltCnt <= 4'h0;
            multSelect <= MULT_BYPASS;
            sleepField <= SLEEP_RESET;
            pendCode <= SLEEP_NONE;
        end
        else
        begin
            state <= next_state;
            // Counter restarts on every state change so each wait is measured from its own entry
            waitCnt <= (next_state != state) ? '0 : waitCnt + LOCK_W'(1);
            haltCnt <= (next_state != state) ? 4'h0 : haltCnt + 4'h1;
            if (state == ST_STRAP)
                multSelect <= strapSync;
            if (sleepWrite & (state != ST_STOP))
                sleepField <= sleepWdata;
            else if ((state == ST_HALT) & wakeNow)
                sleepField <= SLEEP_NONE;
            if ((state == ST_RUN) & sleepWrite)
                pendCode <= sleepWdata;
        end
    end
    // Clock gate enables; interrupt and transfer clocks survive core halt
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cpuClockEn <= 1'b0;
            intrClockEn <= 1'b0;
            xferClockEn <= 1'b0;
            pllOutRun <= 1'b1;
            pllInRun <= 1'b1;
            resumeIsr <= 1'b0;
            resumeDirect <= 1'b0;
        end
        else
        begin
            cpuClockEn <= (next_state == ST_RUN) | (next_state == ST_HALT_PEND) | (next_state == ST_STOP_PEND);
            intrClockEn <= refRun;
            xferClockEn <= refRun;
            pllOutRun <= next_state != ST_STOP;
            pllInRun <= ~((next_state == ST_STOP) & (pendCode == SLEEP_PLL_IN_STOP));
            resumeIsr <= (state == ST_HALT) & wakeNow & irqEnabled;
            resumeDirect <= (state == ST_HALT) & wakeNow & ~irqEnabled;
        end
    end
    // Peripheral clock dividers; they run in halt, freeze in stop modes
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            div4Cnt <= 1'b0;
            div6Cnt <= 2'h0;
            periphClockDiv4 <= 1'b0;
            periphClockDiv6 <= 1'b0;
        end
        else if (refRun)
        begin
            div4Cnt <= ~div4Cnt;
            div6Cnt <= (div6Cnt == 2'h2) ? 2'h0 : div6Cnt + 2'h1;
            if (div4Cnt)
                periphClockDiv4 <= ~periphClockDiv4;
            if (div6Cnt == 2'h2)
                periphClockDiv6 <= ~periphClockDiv6;
        end
    end
    // Write side of the bus: address and data taken in either order, response after both
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddrHeld <= '0;
            wDataHeld <= 32'h00000000;
            wStrbHeld <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else
        begin
            if (awTake)
            begin
                awHeld <= 1'b1;
                awAddrHeld <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (wTake)
            begin
                wHeld <= 1'b1;
                wDataHeld <= s_axi_wdata;
                wStrbHeld <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (doWrite)
            begin
                awHeld <= 1'b0;
                wHeld <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= writeResp;
            end
            else if (s_axi_bvalid & s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Read side of the bus: one read in flight, data one cycle after the address
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (arTake)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= readWord;
            s_axi_rresp <= readResp;
        end
        else if (s_axi_rvalid & s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule

/* File: pmpd_clock_ctrl_props.sv */
// Concurrent checks on the ports of the clock controller
`timescale 1ns/1ps
module pmpd_props
#(
    parameter int LOCK_CYCLES = 7500
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic multSelectHi,
    input wire logic multSelectLo,
    input wire logic irqEnabled,
    input wire logic cpuClockEn,
    input wire logic intrClockEn,
    input wire logic xferClockEn,
    input wire logic pllOutRun,
    input wire logic pllInRun,
    input wire logic periphClockDiv4,
    input wire logic periphClockDiv6,
    input wire logic resumeIsr,
    input wire logic resumeDirect
);
    logic [15:0] upCnt; // Edges since reset release
    // Saturates so a long run cannot wrap and fake a fresh reset
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            upCnt <= 16'h0000;
        else if (upCnt != 16'hffff)
            upCnt <= upCnt + 16'h0001;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    property p_reserved; multSelectHi && multSelectLo |-> !cpuClockEn; endproperty
    a_reserved: assert property (p_reserved) else $error("core clock with reserved strap");
    property p_bypass; !multSelectHi && !multSelectLo && upCnt == 16'h0008 |-> cpuClockEn; endproperty
    a_bypass: assert property (p_bypass) else $error("bypass start delayed");
    property p_lock; cpuClockEn && (multSelectHi != multSelectLo) |-> int'(upCnt) >= LOCK_CYCLES; endproperty
    a_lock: assert property (p_lock) else $error("core clock before lock wait");
    property p_halt_aux; $fell(cpuClockEn) && pllOutRun |-> intrClockEn && xferClockEn; endproperty
    a_halt_aux: assert property (p_halt_aux) else $error("aux clocks gated in halt");
    property p_wake_isr; resumeIsr |-> $past(irqEnabled) ##1 (!resumeIsr && cpuClockEn); endproperty
    a_wake_isr: assert property (p_wake_isr) else $error("bad service wake");
    property p_wake_dir; resumeDirect |-> !$past(irqEnabled) ##1 (!resumeDirect && cpuClockEn); endproperty
    a_wake_dir: assert property (p_wake_dir) else $error("bad direct wake");
    property p_stop_hold; !pllOutRun |=> !pllOutRun; endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("stop left without reset");
    property p_in_stop; !pllInRun |-> !pllOutRun && !cpuClockEn; endproperty
    a_in_stop: assert property (p_in_stop) else $error("input stop leaves clocks on");
    // Dividers freeze in the stop modes, so those cycles are left out
    property p_div4;
        disable iff (!rst_b || !pllOutRun) $rose(periphClockDiv4) |=> periphClockDiv4 ##1 !periphClockDiv4;
    endproperty
    a_div4: assert property (p_div4) else $error("quarter clock shape");
    property p_div6;
        disable iff (!rst_b || !pllOutRun) $rose(periphClockDiv6) |=> periphClockDiv6 [*2] ##1 !periphClockDiv6;
    endproperty
    a_div6: assert property (p_div6) else $error("sixth clock shape");
    c_wake_isr: cover property (resumeIsr);
    c_wake_dir: cover property (resumeDirect);
    c_in_stop: cover property (!pllInRun);
endmodule
bind pmpd_clock_ctrl pmpd_props #(.LOCK_CYCLES(LOCK_CYCLES)) u_props (.clk(clk), .rst_b(rst_b),
    .multSelectHi(multSelectHi), .multSelectLo(multSelectLo), .irqEnabled(irqEnabled),
    .cpuClockEn(cpuClockEn), .intrClockEn(intrClockEn), .xferClockEn(xferClockEn), .pllOutRun(pllOutRun),
    .pllInRun(pllInRun), .periphClockDiv4(periphClockDiv4), .periphClockDiv6(periphClockDiv6),
    .resumeIsr(resumeIsr), .resumeDirect(resumeDirect));

/* File: pmpd_far_side.sv */
// Model of the strap resistors and the interrupt source beside the controller
`timescale 1ns/1ps
module pmpd_far_side
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic strapFit,
    input wire logic [1:0] strapVal,
    input wire logic raiseIrq,
    input wire logic resumeIsr,
    input wire logic resumeDirect,
    output logic multSelectHi,
    output logic multSelectLo,
    output logic irqPending
);
    // Without fitted pull-ups the internal pull-downs win, so both straps read low
    assign multSelectHi = strapFit & strapVal[1];
    assign multSelectLo = strapFit & strapVal[0];
    // Interrupt stays pending until the core takes it on wake
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            irqPending <= 1'b0;
        else if (resumeIsr || resumeDirect)
            irqPending <= 1'b0;
        else if (raiseIrq)
            irqPending <= 1'b1;
    end
endmodule

/* File: testbench.sv */
// Self-checking bench for the PLL mode and power-down controller
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; $display("FAIL %s expected %h seen %h", nm, e, g); end end
module testbench;
    import pmpd_pkg::*;
    localparam int LOCK = 20; // Short lock wait keeps the run brief
    logic clk = 1'b0, rst_b = 1'b0, strapFit = 1'b0, raiseIrq = 1'b0, irqEnabled = 1'b0, irqPending;
    logic [1:0] strapVal = 2'h0, bresp, rresp, lastResp;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rdVal;
    logic [3:0] wstrb = 4'h0, isrCnt = 4'h0, dirCnt = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, multSelectHi, multSelectLo;
    logic cpuClockEn, intrClockEn, xferClockEn, pllOutRun, pllInRun, resumeIsr, resumeDirect;
    logic [5:0] code;
    logic div4, div6, d4, d6; // Peripheral clock outputs and their earlier samples
    int error_cnt = 0, check_count = 0, cyc = 0, wEdge, n;
    // 40 MHz clock
    initial
    begin
        forever #12.5 clk = ~clk;
    end
    // Edge counter and wake pulse tallies
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (resumeIsr === 1'b1) isrCnt <= isrCnt + 4'h1;
        if (resumeDirect === 1'b1) dirCnt <= dirCnt + 4'h1;
    end
    pmpd_clock_ctrl #(.LOCK_CYCLES(LOCK)) dut (.clk(clk), .rst_b(rst_b), .multSelectHi(multSelectHi),
        .multSelectLo(multSelectLo), .irqPending(irqPending), .irqEnabled(irqEnabled), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .cpuClockEn(cpuClockEn), .intrClockEn(intrClockEn), .xferClockEn(xferClockEn), .pllOutRun(pllOutRun),
        .pllInRun(pllInRun), .periphClockDiv4(div4), .periphClockDiv6(div6), .resumeIsr(resumeIsr),
        .resumeDirect(resumeDirect));
    pmpd_far_side partner (.clk(clk), .rst_b(rst_b), .strapFit(strapFit), .strapVal(strapVal),
        .raiseIrq(raiseIrq), .resumeIsr(resumeIsr), .resumeDirect(resumeDirect),
        .multSelectHi(multSelectHi), .multSelectLo(multSelectLo), .irqPending(irqPending));
    task automatic print_verdict;
        $display("Checks %0d, mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Reset for five cycles with the given straps, then count edges until the core clock runs
    task automatic reset_run(input logic fit, input logic [1:0] val);
        rst_b <= 1'b0;
        strapFit <= fit;
        strapVal <= val;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        n = 0;
        while (cpuClockEn !== 1'b1 && n < LOCK + 12)
        begin
            @(posedge clk);
            n++;
        end
    endtask
    // Write: address and data offered together, each dropped once taken, then the response
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic done;
        done = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done)
        begin
            @(posedge clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1)
            begin
                lastResp = bresp;
                wEdge = cyc;
                bready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask
    // Read: address held until taken, data kept at the edge that shows rvalid
    task automatic axi_rd(input logic [7:0] a);
        logic done;
        done = 1'b0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done)
        begin
            @(posedge clk);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1)
            begin
                rdVal = rdata;
                lastResp = rresp;
                rready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask
    initial
    begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        print_verdict();
    end
    initial
    begin
        reset_run(1'b0, 2'h3);
        `CHK("bypass start", 1'b1, n < 8)
        d4 = div4;
        d6 = div6;
        repeat (2) @(posedge clk);
        `CHK("quarter clock", 1'b1, (d4 ^ div4) === 1'b1)
        @(posedge clk);
        `CHK("sixth clock", 1'b1, (d6 ^ div6) === 1'b1)
        axi_rd(OFFS_CPU_CONTROL_STATUS);
        `CHK("field reset", 32'h0, rdVal)
        axi_rd(8'h08);
        `CHK("unmapped", {RESP_SLVERR, 32'h0}, {lastResp, rdVal})
        axi_wr(OFFS_CLOCK_STATUS, 32'hffffffff, 4'hf);
        `CHK("status write", RESP_OKAY, lastResp)
        axi_wr(8'h08, 32'hffffffff, 4'hf);
        `CHK("unmapped write", RESP_SLVERR, lastResp)
        axi_wr(OFFS_CPU_CONTROL_STATUS, 32'h1400, 4'hd);
        axi_rd(OFFS_CPU_CONTROL_STATUS);
        `CHK("lane off", 32'h0, rdVal)
        axi_wr(OFFS_CPU_CONTROL_STATUS, 32'h1400, 4'h2);
        repeat (12) @(posedge clk);
        axi_rd(OFFS_CPU_CONTROL_STATUS);
        `CHK("reserved code", {32'h1400, 1'b1}, {rdVal, cpuClockEn})
        for (int i = 0; i < 2; i++)
        begin
            code = (i == 1) ? SLEEP_HALT_ANY : SLEEP_HALT_ENABLED;
            irqEnabled <= 1'b0;
            axi_wr(OFFS_CPU_CONTROL_STATUS, 32'(code) << SLEEP_LSB, 4'hf);
            while (cpuClockEn === 1'b1) @(posedge clk);
            `CHK("halt delay", 9, cyc - wEdge)
            `CHK("halt aux", 2'b11, {intrClockEn, xferClockEn})
            axi_rd(OFFS_CLOCK_STATUS);
            `CHK("halt status", 6'h0c, rdVal[5:0])
            raiseIrq <= 1'b1;
            @(posedge clk);
            raiseIrq <= 1'b0;
            repeat (10) @(posedge clk);
            `CHK("halt held", 1'(i), cpuClockEn)
            irqEnabled <= 1'b1;
            repeat (4) @(posedge clk);
            `CHK("wake kind", (i == 1) ? 8'h11 : 8'h10, {isrCnt, dirCnt})
            axi_rd(OFFS_CPU_CONTROL_STATUS);
            `CHK("woken", {32'h0, 1'b1}, {rdVal, cpuClockEn})
        end
        axi_wr(OFFS_CPU_CONTROL_STATUS, 32'(SLEEP_PLL_OUT_STOP) << SLEEP_LSB, 4'hf);
        repeat (12) @(posedge clk);
        raiseIrq <= 1'b1;
        repeat (10) @(posedge clk);
        raiseIrq <= 1'b0;
        `CHK("output stop", 3'b010, {pllOutRun, pllInRun, cpuClockEn})
        axi_rd(OFFS_CLOCK_STATUS);
        `CHK("stop status", 6'h14, rdVal[5:0])
        axi_wr(OFFS_CPU_CONTROL_STATUS, 32'h0, 4'hf);
        axi_rd(OFFS_CPU_CONTROL_STATUS);
        `CHK("stop keeps field", 32'(SLEEP_PLL_OUT_STOP) << SLEEP_LSB, rdVal)
        for (int m = 1; m < 4; m++)
        begin
            reset_run(1'b1, 2'(m));
            `CHK("lock wait", m < 3, n >= LOCK && n < LOCK + 12)
            axi_rd(OFFS_CLOCK_STATUS);
            `CHK("status", (m < 3) ? 6'h04 | 6'(m) : 6'h23, rdVal[5:0])
            if (m == 2)
            begin
                axi_wr(OFFS_CPU_CONTROL_STATUS, 32'(SLEEP_PLL_IN_STOP) << SLEEP_LSB, 4'hf);
                repeat (12) @(posedge clk);
                `CHK("input stop", 3'b000, {pllOutRun, pllInRun, cpuClockEn})
            end
        end
        print_verdict();
    end
endmodule
